// ### src/hpb_port.sv
// parallel host bus port: registers, dma requests, straps
`timescale 1ns/1ns
`include "hpb_map.svh"
module hpb_port
  import hpb_pkg::*;
#(
  parameter int READY_CYCLES = `HPB_READY_CYCLES,
  parameter int FIFO_DEPTH = `HPB_FIFO_DEPTH
) (
  // clock, reset, enable
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  // host bus pins
  input wire logic host_bus_clock,
  input wire logic host_select_n,
  input wire logic host_read_n,
  input wire logic host_write_n,
  input wire logic host_data_out_enable_n,
  input wire logic [4:0] host_reg_select,
  input wire logic [15:0] host_data_in,
  output logic [15:0] host_data_out,
  output logic host_data_oe,
  // dma handshakes
  input wire logic rx_dma_ack_n,
  input wire logic tx_dma_ack_n,
  output logic rx_dma_req,
  output logic tx_dma_req,
  // open-drain interrupt
  output logic host_irq_n_out,
  output logic host_irq_n_oe,
  // straps
  input wire logic boot_rom_enable,
  input wire logic test_strap_n,
  // core side: receive words
  input wire logic rx_valid,
  input wire logic [15:0] rx_data,
  output logic rx_ready,
  // core side: transmit words
  input wire logic tx_need,
  output logic tx_valid,
  output logic [15:0] tx_data,
  // core side: events and status
  input wire logic irq_request,
  output logic wr_valid,
  output logic [4:0] wr_addr,
  output logic [15:0] wr_data,
  output logic device_ready,
  output logic rom_fetch_enable,
  output logic factory_test_mode
);
  localparam int CW = $clog2(READY_CYCLES + 1);

  // synchronised pins
  logic [`HPB_PIN_W-1:0] pins_s;
  logic hclk_s;
  logic cs_n_s;
  logic rd_n_s;
  logic wr_n_s;
  logic en_n_s;
  logic rxack_n_s;
  logic txack_n_s;
  logic rom_s;
  logic test_n_s;
  hpb_sel_t sel_s;
  hpb_word_t din_s;
  logic hclk_d; // previous host clock level
  logic hedge; // host clock rising edge

  // start-up state
  hpb_state_t state;
  hpb_state_t next_state;
  logic [CW-1:0] ready_cnt;
  logic [CW-1:0] next_ready_cnt;
  logic next_device_ready;
  logic next_rom;
  logic next_test;

  // register file and write path
  hpb_word_t regs [`HPB_REG_COUNT];
  hpb_word_t next_regs [`HPB_REG_COUNT];
  logic wr_done; // one store per strobe
  logic next_wr_done;
  logic next_wr_valid;
  hpb_sel_t next_wr_addr;
  hpb_word_t next_wr_data;
  logic next_tx_valid;
  hpb_word_t next_tx_data;

  // read path
  logic rd_act; // a read is being presented
  logic rx_pend; // head word handed out, pop at end
  logic next_rx_pend;
  logic next_oe;
  hpb_word_t next_dout;
  logic rx_pop;
  logic fifo_valid;
  hpb_word_t fifo_data;

  // requests
  logic next_rx_req;
  logic next_tx_req;
  logic next_irq_oe;
  logic ce_q; // clock enable of previous cycle

  // true where the receive fifo is the data source
  function automatic logic rx_sel(input logic ack_n,
                                  input hpb_sel_t a);
    rx_sel = !ack_n || (a == `HPB_ADDR_RX_DATA);
  endfunction : rx_sel

  // true where the register file holds the word
  function automatic logic plain_reg(input hpb_sel_t a);
    plain_reg = (a != `HPB_ADDR_RX_DATA) &&
                (a != `HPB_ADDR_STATUS);
  endfunction : plain_reg

  // every pin level crosses two flops first
  hpb_sync #(
    .W(`HPB_PIN_W),
    .RST_VAL(`HPB_PIN_RESET)
  ) u_sync (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .d({host_bus_clock, host_select_n, host_read_n,
        host_write_n, host_data_out_enable_n, rx_dma_ack_n,
        tx_dma_ack_n, boot_rom_enable, test_strap_n,
        host_reg_select, host_data_in}),
    .q(pins_s)
  );

  assign {hclk_s, cs_n_s, rd_n_s, wr_n_s, en_n_s, rxack_n_s,
          txack_n_s, rom_s, test_n_s, sel_s, din_s} = pins_s;

  // receive words wait here for the host
  hpb_fifo #(
    .WIDTH(`HPB_DATA_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .in_valid(rx_valid),
    .in_data(rx_data),
    .in_ready(rx_ready),
    .out_valid(fifo_valid),
    .out_data(fifo_data),
    .out_ready(rx_pop)
  );

  // accesses act on the host clock rising edge
  assign hedge = hclk_s && !hclk_d;
  // open drain: the pin is only ever pulled low
  assign host_irq_n_out = 1'b0;

  // start-up sequence: straps, then ready delay
  always_comb
  begin
    next_state = state;
    next_ready_cnt = ready_cnt;
    next_device_ready = device_ready;
    next_rom = rom_fetch_enable;
    next_test = factory_test_mode;
    unique case (state)
      HPB_WAIT:
      begin
        next_ready_cnt = CW'(ready_cnt + 1'b1);
        // straps have crossed the synchroniser here
        if (ready_cnt == CW'(`HPB_STRAP_WAIT))
        begin
          next_rom = rom_s;
          next_test = !test_n_s;
        end
        if (ready_cnt == CW'(READY_CYCLES - 1))
        begin
          next_state = HPB_READY;
          next_device_ready = 1'b1;
        end
      end
      HPB_READY:
        next_device_ready = 1'b1;
    endcase
  end

  // register start-up state
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      state <= HPB_WAIT;
      ready_cnt <= '0;
      device_ready <= 1'b0;
      rom_fetch_enable <= 1'b0;
      factory_test_mode <= 1'b0;
      hclk_d <= 1'b1; // matches synchroniser reset level, no false edge
      ce_q <= 1'b0;
    end
    else
    begin
      ce_q <= clk_en;
      if (clk_en)
      begin
        state <= next_state;
        ready_cnt <= next_ready_cnt;
        device_ready <= next_device_ready;
        rom_fetch_enable <= next_rom;
        factory_test_mode <= next_test;
        hclk_d <= hclk_s;
      end
    end
  end

  // write strobes: store, report, or pass to transmit
  always_comb
  begin
    next_regs = regs;
    next_wr_done = wr_done && !wr_n_s;
    next_wr_valid = 1'b0;
    next_wr_addr = wr_addr;
    next_wr_data = wr_data;
    next_tx_valid = 1'b0;
    next_tx_data = tx_data;
    if (device_ready && hedge && !wr_n_s && !wr_done)
    begin
      if (!txack_n_s)
      begin
        // dma acknowledge selects the transmit path
        next_tx_valid = 1'b1;
        next_tx_data = din_s;
        next_wr_done = 1'b1;
      end
      else if (!cs_n_s)
      begin
        next_wr_done = 1'b1;
        if (plain_reg(sel_s))
        begin
          next_regs[sel_s] = din_s;
          next_wr_valid = 1'b1;
          next_wr_addr = sel_s;
          next_wr_data = din_s;
        end
      end
    end
  end

  // register file and write results
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      for (int i = 0; i < `HPB_REG_COUNT; i++)
        regs[i] <= `HPB_REG_RESET;
      wr_done <= 1'b0;
      wr_valid <= 1'b0;
      wr_addr <= '0;
      wr_data <= '0;
      tx_valid <= 1'b0;
      tx_data <= '0;
    end
    else if (clk_en)
    begin
      regs <= next_regs;
      wr_done <= next_wr_done;
      wr_valid <= next_wr_valid;
      wr_addr <= next_wr_addr;
      wr_data <= next_wr_data;
      tx_valid <= next_tx_valid;
      tx_data <= next_tx_data;
    end
  end

  // read strobes: drive bus, pop fifo when strobe ends
  always_comb
  begin
    rd_act = device_ready && !rd_n_s && !en_n_s &&
             (!cs_n_s || !rxack_n_s);
    next_oe = rd_act;
    next_dout = host_data_out;
    next_rx_pend = rx_pend && !rd_n_s;
    rx_pop = rx_pend && rd_n_s;
    if (rd_act)
    begin
      if (rx_sel(rxack_n_s, sel_s))
        next_dout = fifo_data;
      else if (sel_s == `HPB_ADDR_STATUS)
      begin
        next_dout = '0;
        next_dout[`HPB_ST_RX_AVAIL] = fifo_valid;
        next_dout[`HPB_ST_TX_NEED] = tx_need;
        next_dout[`HPB_ST_IRQ] = irq_request;
        next_dout[`HPB_ST_READY] = device_ready;
      end
      else
        next_dout = regs[sel_s];
      if (hedge && fifo_valid && rx_sel(rxack_n_s, sel_s))
        next_rx_pend = 1'b1;
    end
  end

  // dma requests drop while acknowledged
  always_comb
  begin
    next_rx_req = device_ready && fifo_valid && rxack_n_s &&
                  !rx_pend;
    next_tx_req = device_ready && tx_need &&
                  txack_n_s;
    next_irq_oe = device_ready && irq_request;
  end

  // register read path and requests
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      host_data_oe <= 1'b0;
      host_data_out <= '0;
      rx_pend <= 1'b0;
      rx_dma_req <= 1'b0;
      tx_dma_req <= 1'b0;
      host_irq_n_oe <= 1'b0;
    end
    else if (clk_en)
    begin
      host_data_oe <= next_oe;
      host_data_out <= next_dout;
      rx_pend <= next_rx_pend;
      rx_dma_req <= next_rx_req;
      tx_dma_req <= next_tx_req;
      host_irq_n_oe <= next_irq_oe;
    end
  end

  // checks on the port behaviour
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n || !clk_en || !ce_q);

  a_ready_delay: assert property (
    state == HPB_WAIT && ready_cnt != CW'(READY_CYCLES - 1)
    |=> !device_ready)
    else $error("ready raised before the delay ran out");

  a_reset_default: assert property (
    @(posedge sys_clk) disable iff (1'b0)
    !rst_n |=> !device_ready && !host_data_oe && !rx_dma_req)
    else $error("reset did not restore defaults");

  a_rom_strap: assert property (
    device_ready && $past(device_ready)
    |-> $stable(rom_fetch_enable))
    else $error("rom enable changed after capture");

  a_test_strap: assert property (
    device_ready && $past(device_ready)
    |-> $stable(factory_test_mode))
    else $error("test mode changed after capture");

  a_drive_read: assert property (
    host_data_oe |-> $past(!rd_n_s && !en_n_s))
    else $error("data bus driven without read and enable");

  a_select_write: assert property (
    wr_valid |-> $past(!cs_n_s && hedge))
    else $error("register write without select");

  a_write_store: assert property (
    wr_valid |-> regs[wr_addr] == wr_data)
    else $error("written word not stored");

  a_rx_request: assert property (
    !rxack_n_s ##1 !rxack_n_s |-> !rx_dma_req)
    else $error("receive request held during acknowledge");

  a_tx_request: assert property (
    tx_dma_req |-> $past(tx_need && txack_n_s))
    else $error("transmit request without need");

  a_irq_level: assert property (
    device_ready && $past(device_ready)
    |-> host_irq_n_oe == $past(irq_request))
    else $error("interrupt pin does not follow request");

  c_ready: cover property ($rose(device_ready));
  c_rx_pop: cover property (rx_pop);
  c_tx_word: cover property (tx_valid);
  c_reg_write: cover property (wr_valid);
endmodule : hpb_port

// ### pkg/hpb_map.svh
// constants of the host parallel bus port
// What this block does
// - device ready 2 ms after reset release
// - reset restores factory default register values
// - rom strap high enables internal rom fetch
// - low test strap selects factory test mode
// - five select lines pick one of 32 registers
// - 16-bit three-state bidirectional host data bus
// - drive data only while read and enable low
// - respond only while chip select is low; a dma acknowledge also opens a read or write without chip select
// - read strobe returns addressed register contents
// - write strobe stores bus word in register
// - host accesses synchronised to host bus clock
// - receive request high while receive data waits
// - transmit request high while transmit data needed
// - open-drain interrupt pulled low for service
`ifndef HPB_MAP_SVH
`define HPB_MAP_SVH
`define HPB_CLK_KHZ 20000
`define HPB_READY_TIME_MS 2
`define HPB_READY_CYCLES (`HPB_READY_TIME_MS * `HPB_CLK_KHZ)
`define HPB_STRAP_WAIT 2
`define HPB_REG_COUNT 32
`define HPB_DATA_W 16
`define HPB_SEL_W 5
`define HPB_FIFO_DEPTH 32
`define HPB_ADDR_RX_DATA 5'h00
`define HPB_ADDR_STATUS 5'h01
`define HPB_REG_RESET 16'h0000
`define HPB_ST_RX_AVAIL 0
`define HPB_ST_TX_NEED 1
`define HPB_ST_IRQ 2
`define HPB_ST_READY 3
`define HPB_PIN_W 30
`define HPB_PIN_RESET 30'h3FFFFFFF
`endif

// ### pkg/hpb_pkg.sv
// types of the host parallel bus port
package hpb_pkg;
  // start-up phases
  typedef enum logic [0:0] {HPB_WAIT, HPB_READY} hpb_state_t;
  // one host word
  typedef logic [15:0] hpb_word_t;
  // register select
  typedef logic [4:0] hpb_sel_t;
endpackage : hpb_pkg

// ### src/hpb_sync.sv
// two-stage synchroniser for pin levels
`timescale 1ns/1ns
module hpb_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // clock, reset, enable
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  // level in from a foreign domain
  input wire logic [W-1:0] d,
  // level usable in sys_clk domain
  output logic [W-1:0] q
);
  logic [W-1:0] meta; // first stage, read only by q
  logic [W-1:0] next_meta;
  logic [W-1:0] next_q;

  // next values of both stages
  always_comb
  begin
    next_meta = d;
    next_q = meta;
  end

  // register the stages
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      meta <= RST_VAL;
      q <= RST_VAL;
    end
    else if (clk_en)
    begin
      meta <= next_meta;
      q <= next_q;
    end
  end
endmodule : hpb_sync

// ### src/hpb_fifo.sv
// receive data fifo with valid/ready on both sides
`timescale 1ns/1ns
module hpb_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 32
) (
  // clock, reset, enable
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  // fill side
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  // drain side
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH]; // storage
  logic [AW-1:0] wr_ptr; // next slot to fill
  logic [AW-1:0] rd_ptr; // head slot
  logic [AW:0] count; // words held
  logic [AW-1:0] next_wr_ptr;
  logic [AW-1:0] next_rd_ptr;
  logic [AW:0] next_count;
  logic next_in_ready;
  logic next_out_valid;
  logic push;
  logic pop;

  // head word is always visible
  assign out_data = mem[rd_ptr];

  // pointer and flag updates
  always_comb
  begin
    push = in_valid && in_ready;
    pop = out_valid && out_ready;
    next_wr_ptr = push ? AW'(wr_ptr + 1'b1) : wr_ptr;
    next_rd_ptr = pop ? AW'(rd_ptr + 1'b1) : rd_ptr;
    next_count = (AW+1)'(count + (AW+1)'(push) - (AW+1)'(pop));
    next_in_ready = next_count != (AW+1)'(DEPTH);
    next_out_valid = next_count != '0;
  end

  // register pointers, flags and storage
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
      in_ready <= 1'b1;
      out_valid <= 1'b0;
    end
    else if (clk_en)
    begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
      count <= next_count;
      in_ready <= next_in_ready;
      out_valid <= next_out_valid;
      if (push)
        mem[wr_ptr] <= in_data;
    end
  end
endmodule : hpb_fifo

// ### verification/hpb_host_model.sv
// host processor model that drives the parallel bus pins
`timescale 1ns/1ns
module hpb_host_model (
  // system clock
  input wire logic sys_clk,
  // device side of the data bus
  input wire logic [15:0] host_data_out,
  input wire logic host_data_oe,
  // host bus pins
  output logic host_bus_clock,
  output logic host_select_n,
  output logic host_read_n,
  output logic host_write_n,
  output logic host_data_out_enable_n,
  output logic [4:0] host_reg_select,
  output logic [15:0] host_data_in,
  output logic rx_dma_ack_n,
  output logic tx_dma_ack_n
);
  // write word and whether the host drives it
  logic [15:0] dout;
  logic drive;
  // last bus level, shown inverted while nobody drives
  logic [15:0] last;
  // idle pins, bus clock stands low outside accesses
  initial
  begin
    {host_select_n, host_read_n, host_write_n} = 3'h7;
    {host_data_out_enable_n, rx_dma_ack_n, tx_dma_ack_n} = 3'h7;
    host_bus_clock = 0;
    host_reg_select = 5'h00;
    dout = 16'h0000;
    drive = 0;
    last = 16'h0000;
  end
  // wire level from both drivers
  assign host_data_in = (host_data_oe === 1'b1) ? host_data_out :
                        drive ? dout : ~last;
  // remember the bus level each cycle
  always @(posedge sys_clk)
    last <= host_data_in;
  // one access: write or read, by select or by dma acknowledge
  task acc(input logic w, cs, en, rxa, txa, input logic [4:0] sel,
           input logic [15:0] d, output logic [15:0] q);
    @(posedge sys_clk);
    #5;
    host_reg_select = sel;
    dout = d;
    drive = w;
    host_select_n = !cs;
    rx_dma_ack_n = !rxa;
    tx_dma_ack_n = !txa;
    host_write_n = !w;
    host_read_n = w;
    host_data_out_enable_n = w | !en;
    repeat (2) @(posedge sys_clk);
    #5 host_bus_clock = 1;
    repeat (3) @(posedge sys_clk);
    #5 host_bus_clock = 0;
    repeat (2) @(posedge sys_clk);
    #5;
    q = host_data_in;
    {host_select_n, host_read_n, host_write_n} = 3'h7;
    {host_data_out_enable_n, rx_dma_ack_n, tx_dma_ack_n} = 3'h7;
    drive = 0;
    host_reg_select = ~sel;
    repeat (4) @(posedge sys_clk);
    #5;
  endtask : acc
endmodule : hpb_host_model

// ### verification/tb_hpb_port.sv
// self-checking testbench of the host parallel bus port
`timescale 1ns/1ns
module tb_hpb_port;
  import hpb_pkg::*;
  // short start-up count for simulation
  localparam int RC = 20;
  // clock, reset, straps, core inputs
  logic sys_clk = 0;
  logic rst_n = 0;
  logic rom = 1;
  logic tstn = 1;
  logic rx_valid = 0;
  logic tx_need = 0;
  logic irq_request = 0;
  logic ce = 1;
  logic [15:0] rx_data = 16'h0000;
  // pins between model and device
  logic hclk, cs_n, rd_n, wr_n, en_n, rxa_n, txa_n;
  logic [4:0] sel;
  logic [15:0] din, dout, tx_data, wr_data, q;
  logic oe, rx_req, tx_req, irq_out, irq_oe, rx_ready, tx_valid;
  logic wr_valid, ready, rom_fetch, test_mode;
  logic [4:0] wr_addr;
  // counters, pulse captures
  int n_errors = 0;
  int num_checks = 0;
  int wcnt = 0;
  int tcnt = 0;
  logic oe_seen = 0;
  logic [4:0] wa;
  logic [15:0] wd, td;
  always #25 sys_clk = ~sys_clk;
  hpb_port #(.READY_CYCLES(RC), .FIFO_DEPTH(32)) DUT (
    .sys_clk(sys_clk), .rst_n(rst_n), .clk_en(ce),
    .host_bus_clock(hclk), .host_select_n(cs_n), .host_read_n(rd_n),
    .host_write_n(wr_n), .host_data_out_enable_n(en_n),
    .host_reg_select(sel), .host_data_in(din), .host_data_out(dout),
    .host_data_oe(oe), .rx_dma_ack_n(rxa_n), .tx_dma_ack_n(txa_n),
    .rx_dma_req(rx_req), .tx_dma_req(tx_req),
    .host_irq_n_out(irq_out), .host_irq_n_oe(irq_oe),
    .boot_rom_enable(rom), .test_strap_n(tstn), .rx_valid(rx_valid),
    .rx_data(rx_data), .rx_ready(rx_ready), .tx_need(tx_need),
    .tx_valid(tx_valid), .tx_data(tx_data), .irq_request(irq_request),
    .wr_valid(wr_valid), .wr_addr(wr_addr), .wr_data(wr_data),
    .device_ready(ready), .rom_fetch_enable(rom_fetch),
    .factory_test_mode(test_mode));
  hpb_host_model host (
    .sys_clk(sys_clk), .host_data_out(dout), .host_data_oe(oe),
    .host_bus_clock(hclk), .host_select_n(cs_n), .host_read_n(rd_n),
    .host_write_n(wr_n), .host_data_out_enable_n(en_n),
    .host_reg_select(sel), .host_data_in(din),
    .rx_dma_ack_n(rxa_n), .tx_dma_ack_n(txa_n));
  // capture one-cycle pulses and any bus drive
  always @(posedge sys_clk)
  begin
    if (wr_valid === 1'b1)
    begin
      wcnt <= wcnt + 1;
      wa <= wr_addr;
      wd <= wr_data;
    end
    if (tx_valid === 1'b1)
    begin
      tcnt <= tcnt + 1;
      td <= tx_data;
    end
    if (oe === 1'b1)
      oe_seen <= 1;
  end
  // compare and report
  task chk(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("unexpected at %0t: %h vs %h", $time, seen, exp);
    end
  endtask : chk
  // single-bit compare
  task chk1(input logic seen, input logic exp);
    chk({15'h0000, seen}, {15'h0000, exp});
  endtask : chk1
  // wait whole cycles, then step off the edge
  task cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #5;
  endtask : cyc
  // reset with given straps, check defaults and start-up time
  task do_reset(input logic r, input logic t);
    cyc(1);
    rst_n = 0;
    rom = r;
    tstn = t;
    cyc(8);
    rst_n = 1;
    cyc(1);
    chk(16'({rx_req, tx_req, irq_oe, ready, rx_ready, irq_out}),
        16'h0002);
    cyc(RC - 3);
    chk1(ready, 0);
    cyc(3);
    chk1(ready, 1);
    chk1(rom_fetch, r);
    chk1(test_mode, !t);
  endtask : do_reset
  // registers written, reported, read back; status is read only
  task t_regs;
    for (int a = 31; a > 2; a -= 3)
    begin
      host.acc(1, 1, 0, 0, 0, 5'(a), 16'hC300 + 16'(a), q);
      chk({11'h000, wa}, 16'(a));
      chk(wd, 16'hC300 + 16'(a));
    end
    chk(16'(wcnt), 16'h000A);
    oe_seen = 0;
    for (int a = 31; a > 2; a -= 3)
    begin
      host.acc(0, 1, 1, 0, 0, 5'(a), 16'h0000, q);
      chk(q, 16'hC300 + 16'(a));
    end
    chk1(oe_seen, 1);
    host.acc(1, 1, 0, 0, 0, 5'h01, 16'hFFFF, q);
    host.acc(0, 1, 1, 0, 0, 5'h01, 16'h0000, q);
    chk(q, 16'h0008);
  endtask : t_regs
  // no select means no store and no drive; read alone does not drive
  task t_select;
    host.acc(1, 0, 0, 0, 0, 5'h04, 16'h1234, q);
    chk(16'(wcnt), 16'h000A);
    cyc(1);
    oe_seen = 0;
    host.acc(0, 0, 1, 0, 0, 5'h04, 16'h0000, q);
    host.acc(0, 1, 0, 0, 0, 5'h04, 16'h0000, q);
    chk1(oe_seen, 0);
    host.acc(0, 1, 1, 0, 0, 5'h04, 16'h0000, q);
    chk(q, 16'hC304);
  endtask : t_select
  // fill the fifo until it refuses, drain by dma and by address
  task t_rx;
    chk1(rx_req, 0);
    for (int i = 0; i < 32; i++)
    begin
      rx_valid = 1;
      rx_data = 16'h1000 + 16'(i);
      cyc(1);
    end
    rx_valid = 0;
    cyc(1);
    chk1(rx_ready, 0);
    chk1(rx_req, 1);
    for (int i = 0; i < 32; i++)
    begin
      host.acc(0, i > 1, 1, i < 2, 0, 5'h00, 16'h0000, q);
      chk(q, 16'h1000 + 16'(i));
      chk1(rx_req, i < 31);
    end
    chk1(rx_ready, 1);
  endtask : t_rx
  // transmit request, word taken under acknowledge
  task t_tx;
    tx_need = 1;
    cyc(2);
    chk1(tx_req, 1);
    host.acc(0, 1, 1, 0, 0, 5'h01, 16'h0000, q);
    chk(q, 16'h000A);
    host.acc(1, 0, 0, 0, 1, 5'h00, 16'hBEEF, q);
    chk(16'(tcnt), 16'h0001);
    chk(td, 16'hBEEF);
    chk1(tx_req, 1);
    tx_need = 0;
    cyc(2);
    chk1(tx_req, 0);
  endtask : t_tx
  // interrupt held off while clock enable is low, then pulled low
  task t_irq;
    ce = 0;
    irq_request = 1;
    cyc(3);
    chk1(irq_oe, 0);
    ce = 1;
    cyc(2);
    chk(16'({irq_oe, irq_out}), 16'h0002);
    host.acc(0, 1, 1, 0, 0, 5'h01, 16'h0000, q);
    chk(q, 16'h000C);
    irq_request = 0;
    cyc(2);
    chk1(irq_oe, 0);
  endtask : t_irq
  // verdict and end of run
  task end_sim;
    if (n_errors == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : end_sim
  // main sequence
  initial
  begin
    do_reset(1, 1);
    t_regs;
    t_select;
    t_rx;
    t_tx;
    t_irq;
    do_reset(0, 0);
    host.acc(0, 1, 1, 0, 0, 5'h1F, 16'h0000, q);
    chk(q, 16'h0000);
    end_sim;
  end
  // watchdog against a hang
  initial
  begin
    #1000000;
    n_errors++;
    end_sim;
  end
endmodule : tb_hpb_port
